// File: bench/ipc_bus_master.sv
// Behavioural register master that issues strobed reads and writes to the bank.
`default_nettype none
module ipc_bus_master (
  // Clock and answer from the bank.
  input  wire logic        clk,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid,
  // Request lines.
  output var  logic        reg_wr,
  output var  logic        reg_rd,
  output var  logic [15:0] reg_addr,
  output var  logic [15:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // All lines idle at time zero.
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  end
  // One write held over exactly one rising edge; idle lines then show the inverse value.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
  endtask
  // One read; the answer is taken in the cycle after the strobe edge.
  task automatic rd(input logic [15:0] a, output logic [15:0] q, output logic v);
    @(negedge clk);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk);
    {reg_rd, reg_addr} = {1'b0, ~a};
    q = reg_rdata;
    v = reg_rvalid;
  endtask
  // A write, with the read of the same word in its own cycle or in the next one.
  task automatic wr_rd(input logic [15:0] a, input logic [15:0] d, input logic same,
                       output logic [15:0] q, output logic v);
    @(negedge clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, same, a, d};
    if (!same) begin
      @(negedge clk);
      {reg_wr, reg_rd} = {1'b0, 1'b1};
    end
    @(negedge clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
    q = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule // ipc_bus_master
`default_nettype wire

// File: bench/ipc_input_pair_config_regs_tb.sv
// Self-checking bench for the input pair setup bank.
`default_nettype none
module ipc_input_pair_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, reg_wr, reg_rd, rv, en5, en6, en7, en8, mv, cjc, rej, v;
  logic [15:0] addr, wdata, rdata, q, d;
  logic [3:0]  tc3, tc4, tc5, tc6;
  logic [2:0]  filt;
  logic [15:0] sh [4];  // Expected word of each place; the fourth is unmapped and reads zero.
  int          mismatches, n_checks, idx;
  ipc_input_pair_config_regs ipc_input_pair_config_regs_inst (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rv),
    .tc_kind_in3(tc3), .tc_kind_in4(tc4), .enable_in5(en5), .enable_in6(en6), .measure_mv_56(mv),
    .cold_junction_56(cjc), .reject_60hz_56(rej), .filter_code_56(filt), .tc_kind_in5(tc5),
    .tc_kind_in6(tc6), .enable_in7(en7), .enable_in8(en8));
  ipc_bus_master ipc_bus_master_inst (.clk(clk), .reg_rdata(rdata), .reg_rvalid(rv), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata));
  // Free-running 100 MHz clock.
  always #5 clk = ~clk;
  // Compare and count.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  // Bits that each place keeps; the rest of the word reads zero.
  function automatic logic [15:0] held(input int i, input logic [15:0] w);
    case (i)
      0: return w & 16'h00ff;
      1: return w;
      2: return w & 16'hc000;
      default: return 16'h0000;
    endcase
  endfunction
  // Read every place plus one unmapped index, then compare the setting outputs.
  task automatic verify();
    for (int i = 0; i < 4; i++) begin
      ipc_bus_master_inst.rd(16'h9c77 + 16'(i), q, v);
      check({15'h0, v}, 16'h0001);
      check(q, sh[i]);
    end
    check({8'h00, tc3, tc4}, sh[0]);
    check({en5, en6, mv, cjc, rej, filt, tc5, tc6}, sh[1]);
    check({en7, en8, 14'h0000}, sh[2]);
  endtask
  // Reset for four cycles; the defaults are enables on, compensation on, filter 010, type J.
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    sh = '{16'h0000, 16'hd200, 16'hc000, 16'h0000};
  endtask
  // Verdict in one place.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence: defaults, all-ones and all-zeros corners, random traffic, reset mid-run.
  initial begin
    clk = 1'b0;
    void'($urandom(32'hddfc2d9a));
    do_reset();
    verify();
    $display("test done: reset values");
    foreach (sh[k]) begin
      for (int i = 0; i < 4; i++) begin
        d = k[0] ? 16'hffff : 16'h0000;
        ipc_bus_master_inst.wr(16'h9c77 + 16'(i), d);
        sh[i] = held(i, d);
      end
      verify();
    end
    $display("test done: corner words");
    repeat (60) begin
      idx = $urandom_range(0, 4);
      d = 16'($urandom);
      ipc_bus_master_inst.wr(idx < 4 ? 16'h9c77 + 16'(idx) : 16'($urandom) & 16'h7fff, d);
      if (idx < 3) sh[idx] = held(idx, d);
      verify();
    end
    $display("test done: random traffic");
    // Back to back: a read in the write's own cycle sees the old word, the next cycle the new one.
    for (int i = 0; i < 3; i++) begin
      d = 16'($urandom);
      ipc_bus_master_inst.wr_rd(16'h9c77 + 16'(i), d, 1'b1, q, v);
      check({15'h0, v}, 16'h0001);
      check(q, sh[i]);
      sh[i] = held(i, d);
      d = 16'($urandom);
      ipc_bus_master_inst.wr_rd(16'h9c77 + 16'(i), d, 1'b0, q, v);
      sh[i] = held(i, d);
      check(q, sh[i]);
    end
    verify();
    $display("test done: back to back");
    do_reset();
    verify();
    $display("test done: second reset");
    complete_run();
  end
  // Watchdog: the run takes under a thousand cycles, so ten thousand is ample margin.
  initial begin
    #100000;
    mismatches++;
    complete_run();
  end
endmodule // ipc_input_pair_config_regs_tb
`default_nettype wire

// File: logic/ipc_input_pair_config_regs.sv
// Configuration holding registers for thermocouple input pairs 3/4, 5/6 and 7/8.
`include "ipc_consts.svh"
`default_nettype none

// Summary of operation
// - Bits 15/14 enable odd/even input, default on
// - Bit 13 picks millivolts, default temperature
// - Bit 12 enables cold-junction compensation, default on
// - Bit 11 picks 60 Hz; filter default 010
// - Inputs 5/6 thermocouple codes, default type J
// - Inputs 3/4 thermocouple codes, default type J
module ipc_input_pair_config_regs (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register access port from the protocol engine.
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  output var  logic [15:0] reg_rdata,
  output var  logic        reg_rvalid,
  // Settings of inputs 3 and 4.
  output var  logic [3:0]  tc_kind_in3,
  output var  logic [3:0]  tc_kind_in4,
  // Settings of inputs 5 and 6.
  output var  logic        enable_in5,
  output var  logic        enable_in6,
  output var  logic        measure_mv_56,
  output var  logic        cold_junction_56,
  output var  logic        reject_60hz_56,
  output var  logic [2:0]  filter_code_56,
  output var  logic [3:0]  tc_kind_in5,
  output var  logic [3:0]  tc_kind_in6,
  // Settings of inputs 7 and 8.
  output var  logic        enable_in7,
  output var  logic        enable_in8
);

  // ****************************************************************
  // Address decode
  // ****************************************************************

  // Decode is needed by both the write and read paths, so it lives in one function.
  function automatic logic [2:0] ipc_decode(input logic [15:0] addr);
    ipc_decode = {addr == `IPC_OFS_PAIR_SEVEN_EIGHT,
                  addr == `IPC_OFS_PAIR_FIVE_SIX,
                  addr == `IPC_OFS_PAIR_THREE_FOUR};
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************

  ipc_pkg::ipc_state_s st;       // Registered state.
  ipc_pkg::ipc_state_s next_st;  // Next state.
  logic [2:0]          sel;      // One-hot register select.

  // Next-state logic: writes store only the bits this bank owns; the rest read as zero.
  always_comb begin
    // The decode is one-hot, so at most one word is touched by a strobe.
    sel      = ipc_decode(reg_addr);
    // Hold every field unless a strobe says otherwise.
    next_st  = st;
    // The answer strobe follows each read strobe by exactly one cycle.
    next_st.rd_valid = reg_rd;
    if (reg_wr) begin
      if (sel[0]) begin
        // Only the thermocouple codes of this pair are held here.
        next_st.pair_three_four_tc = {8'h00, reg_wdata[7:0]};
      end
      if (sel[1]) begin
        // Every field of the 5/6 word is writable as a whole.
        next_st.pair_five_six_setup = reg_wdata;
      end
      if (sel[2]) begin
        // Only the enables are held; other fields belong elsewhere.
        next_st.pair_seven_eight_en = {reg_wdata[15:14], 14'h0000};
      end
    end
    if (reg_rd) begin
      // Unmapped addresses answer zero rather than stale data.
      case (sel)
        3'h1:    next_st.rd_data = st.pair_three_four_tc;
        3'h2:    next_st.rd_data = st.pair_five_six_setup;
        3'h4:    next_st.rd_data = st.pair_seven_eight_en;
        default: next_st.rd_data = 16'h0000;
      endcase
    end
  end

  // State register; reset values give type J, 50 Hz, filter 010, inputs on.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Only constants are loaded here, so the asynchronous branch never samples data.
      // The acquisition side therefore sees documented defaults from the first cycle.
      st.pair_three_four_tc  <= {8'h00, `IPC_TC_DEFAULT, `IPC_TC_DEFAULT};
      st.pair_five_six_setup <= `IPC_PAIR_RESET;
      st.pair_seven_eight_en <= `IPC_EN_ONLY_RESET;
      st.rd_data             <= 16'h0000;
      st.rd_valid            <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs, each straight from the state flip-flops
  // ****************************************************************

  // Every output is a slice of the state flip-flops, with no logic in between.
  // This keeps the settings glitch free for the acquisition side, at the cost
  // of a one-cycle delay between a write and the new setting taking effect.
  assign reg_rdata        = st.rd_data;
  assign reg_rvalid       = st.rd_valid;
  assign tc_kind_in3      = st.pair_three_four_tc[`IPC_TC_ODD_HI:`IPC_TC_ODD_LO];
  assign tc_kind_in4      = st.pair_three_four_tc[`IPC_TC_EVEN_HI:`IPC_TC_EVEN_LO];
  assign enable_in5       = st.pair_five_six_setup[`IPC_BIT_EN_ODD];
  assign enable_in6       = st.pair_five_six_setup[`IPC_BIT_EN_EVEN];
  assign measure_mv_56    = st.pair_five_six_setup[`IPC_BIT_MEAS_MV];
  assign cold_junction_56 = st.pair_five_six_setup[`IPC_BIT_CJC];
  assign reject_60hz_56   = st.pair_five_six_setup[`IPC_BIT_REJ_60];
  assign filter_code_56   = st.pair_five_six_setup[`IPC_FILT_HI:`IPC_FILT_LO];
  assign tc_kind_in5      = st.pair_five_six_setup[`IPC_TC_ODD_HI:`IPC_TC_ODD_LO];
  assign tc_kind_in6      = st.pair_five_six_setup[`IPC_TC_EVEN_HI:`IPC_TC_EVEN_LO];
  assign enable_in7       = st.pair_seven_eight_en[`IPC_BIT_EN_ODD];
  assign enable_in8       = st.pair_seven_eight_en[`IPC_BIT_EN_EVEN];

  // ****************************************************************
  // Assertions
  // ****************************************************************

  // All checks below watch the pins of this bank only. Each write check looks one
  // cycle after the write strobe, which is when the new setting first stands.
  // Reads are answered one cycle after the read strobe.

  // A read of the 5/6 word in the cycle right after a write to it returns the word just written.
  a_write_then_read: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `IPC_OFS_PAIR_FIVE_SIX) ##1 (reg_rd && !reg_wr && reg_addr == `IPC_OFS_PAIR_FIVE_SIX)
    |=> (reg_rvalid && reg_rdata == $past(reg_wdata, 2)))
    else $error("Read of 5/6 word does not return last write");

  // The enables of inputs 5 and 6 follow bits 15 and 14 of the last write.
  a_enable_follows_write: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `IPC_OFS_PAIR_FIVE_SIX) |=> (enable_in5 == $past(reg_wdata[15]) &&
                                                      enable_in6 == $past(reg_wdata[14])))
    else $error("Input 5/6 enable not taken from bits 15 and 14");

  // The measure type follows bit 13 of the last write.
  a_measure_type_bit: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `IPC_OFS_PAIR_FIVE_SIX) |=> measure_mv_56 == $past(reg_wdata[13]))
    else $error("Measure type not taken from bit 13");

  // The cold-junction switch follows bit 12 of the last write.
  a_cjc_bit: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `IPC_OFS_PAIR_FIVE_SIX) |=> cold_junction_56 == $past(reg_wdata[12]))
    else $error("Cold-junction switch not taken from bit 12");

  // Rejection and filter code follow bits 11 and 10 to 8 of the last write.
  a_acq_fields: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `IPC_OFS_PAIR_FIVE_SIX) |=> (reject_60hz_56 == $past(reg_wdata[11]) &&
                                                      filter_code_56 == $past(reg_wdata[10:8])))
    else $error("Rejection or filter field misplaced");

  // The thermocouple codes of inputs 5 and 6 sit in the low byte, odd input on top.
  a_tc_five_six: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `IPC_OFS_PAIR_FIVE_SIX) |=> (tc_kind_in5 == $past(reg_wdata[7:4]) &&
                                                      tc_kind_in6 == $past(reg_wdata[3:0])))
    else $error("Input 5/6 thermocouple codes misplaced");

  // The thermocouple codes of inputs 3 and 4 use the same layout as the 5/6 word.
  a_tc_three_four: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `IPC_OFS_PAIR_THREE_FOUR) |=> (tc_kind_in3 == $past(reg_wdata[7:4]) &&
                                                        tc_kind_in4 == $past(reg_wdata[3:0])))
    else $error("Input 3/4 thermocouple codes misplaced");

  // Without a write the filter code, the input 7 enable and the input 3 code may not drift, or an acquisition would change mode.
  a_settings_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !reg_wr |=> $stable(filter_code_56) && $stable(enable_in7) && $stable(tc_kind_in3))
    else $error("Setting changed without a write");

  // A read of an index that the bank does not own is answered with zero.
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && ipc_decode(reg_addr) == 3'h0) |=> (reg_rvalid && reg_rdata == 16'h0000))
    else $error("Unmapped read not answered with zero");

  // Straight after reset every setting shows its default, before any write lands.
  a_reset_defaults: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> (enable_in5 && enable_in6 && enable_in7 && enable_in8 &&
                      !measure_mv_56 && cold_junction_56 && !reject_60hz_56 &&
                      filter_code_56 == `IPC_FILT_DEFAULT &&
                      tc_kind_in3 == `IPC_TC_DEFAULT && tc_kind_in4 == `IPC_TC_DEFAULT &&
                      tc_kind_in5 == `IPC_TC_DEFAULT && tc_kind_in6 == `IPC_TC_DEFAULT))
    else $error("Setting not at its default after reset");

  // The answer strobe stands for exactly the one cycle after each read strobe.
  a_rvalid_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> reg_rvalid == $past(reg_rd))
    else $error("Read answer strobe not one cycle after the read");

  // Bits that the bank does not hold read back as zero, whatever was written into them.
  a_unheld_high_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == `IPC_OFS_PAIR_THREE_FOUR) |=> reg_rdata[15:8] == 8'h00)
    else $error("Unheld bits of the 3/4 word read nonzero");

  a_unheld_low_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == `IPC_OFS_PAIR_SEVEN_EIGHT) |=> reg_rdata[13:0] == 14'h0000)
    else $error("Unheld bits of the 7/8 word read nonzero");

  // A read in the same cycle as a write to the word answers with the word as it stood before.
  a_read_old_value: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_wr && reg_addr == `IPC_OFS_PAIR_FIVE_SIX)
    |=> reg_rdata == $past({enable_in5, enable_in6, measure_mv_56, cold_junction_56,
                           reject_60hz_56, filter_code_56, tc_kind_in5, tc_kind_in6}))
    else $error("Read during write did not return the old word");

  // ****************************************************************
  // Coverage of the main scenarios
  // ****************************************************************

  // A full write of the 5/6 word.
  c_write_five_six: cover property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == `IPC_OFS_PAIR_FIVE_SIX);
  c_disable_in8: cover property (@(posedge clk) disable iff (!rst_n) !enable_in8);
  c_read_back: cover property (@(posedge clk) disable iff (!rst_n)
    reg_rvalid && reg_rdata != 16'h0000);
  // A write followed at once by a read of the same word.
  c_back_to_back: cover property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `IPC_OFS_PAIR_FIVE_SIX) ##1 (reg_rd && !reg_wr && reg_addr == `IPC_OFS_PAIR_FIVE_SIX));
  // A read and a write in one cycle.
  c_read_during_write: cover property (@(posedge clk) disable iff (!rst_n) reg_rd && reg_wr);

endmodule // ipc_input_pair_config_regs
`default_nettype wire

// File: shared/ipc_consts.svh
// Register offsets, field positions and reset values for the input pair setup bank.
`ifndef IPC_CONSTS_SVH
`define IPC_CONSTS_SVH

// ****************************************************************
// Register offsets (register index on the documented access port)
// ****************************************************************
`define IPC_OFS_PAIR_THREE_FOUR  16'h9c77
`define IPC_OFS_PAIR_FIVE_SIX    16'h9c78
`define IPC_OFS_PAIR_SEVEN_EIGHT 16'h9c79

// ****************************************************************
// Field positions
// ****************************************************************
`define IPC_BIT_EN_ODD     15
`define IPC_BIT_EN_EVEN    14
`define IPC_BIT_MEAS_MV    13
`define IPC_BIT_CJC        12
`define IPC_BIT_REJ_60     11
`define IPC_FILT_HI        10
`define IPC_FILT_LO        8
`define IPC_TC_ODD_HI      7
`define IPC_TC_ODD_LO      4
`define IPC_TC_EVEN_HI     3
`define IPC_TC_EVEN_LO     0

// ****************************************************************
// Reset values
// ****************************************************************
`define IPC_TC_DEFAULT     4'h0
`define IPC_FILT_DEFAULT   3'h2
`define IPC_PAIR_RESET     16'hd200
`define IPC_EN_ONLY_RESET  16'hc000

`endif

// File: shared/ipc_pkg.sv
// Types shared by the input pair setup bank.
`default_nettype none
package ipc_pkg;
  // One sixteen-bit configuration word.
  typedef logic [15:0] ipc_word_t;

  // All state of the register bank.
  typedef struct packed {
    ipc_word_t pair_three_four_tc;   // Thermocouple codes of inputs 3 and 4 (low byte only).
    ipc_word_t pair_five_six_setup;  // Full setup of inputs 5 and 6.
    ipc_word_t pair_seven_eight_en;  // Enable bits of inputs 7 and 8 (top two bits only).
    ipc_word_t rd_data;              // Registered read answer.
    logic      rd_valid;             // Read answer strobe.
  } ipc_state_s;
endpackage : ipc_pkg
`default_nettype wire
